// File: common/ccr_pkg.sv
// Shared constants and types for the clock chip register access block
package ccr_pkg;
	// Link widths and decoded space
	localparam int          ADDR_W   = 11;
	localparam int          DATA_W   = 8;
	localparam logic [10:0] ADDR_TOP = 11'h6FF;
	// Bank select register
	localparam logic [10:0] A_BANK   = 11'h000;
	localparam int          BANK_BIT = 0;
	localparam logic        BANK_RST = 1'h0;
	// Plain configuration registers
	localparam int          CFG_N    = 15;
	localparam logic [10:0] CFG_ADDR [CFG_N] = '{11'h009, 11'h00A, 11'h00B, 11'h00C, 11'h00D,
		11'h00E, 11'h00F, 11'h012, 11'h013, 11'h014, 11'h015, 11'h01B, 11'h01C, 11'h01D, 11'h01E};
	localparam logic [7:0]  CFG_MASK [CFG_N] = '{8'hBF, 8'h7F, 8'h11, 8'h07, 8'h07,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hE3, 8'hFF, 8'hC7, 8'hFF};
	localparam logic [7:0]  CFG_RST  [CFG_N] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Status group: real-time, latched and enable registers
	localparam logic [10:0] A_RT     = 11'h056;
	localparam logic [10:0] A_LATCH  = 11'h059;
	localparam logic [10:0] A_IE     = 11'h05B;
	localparam int          EV_N     = 3;
	localparam int          EV_LSB   = 3;
	localparam logic [2:0]  IE_RST   = 3'h0;
	localparam logic [1:0]  EDGE_RISE = 2'h1;
	localparam logic [1:0]  EDGE_FALL = 2'h2;
	localparam logic [1:0]  EDGE_BOTH = 2'h3;
	localparam logic [1:0]  EV_EDGE [EV_N] = '{EDGE_BOTH, EDGE_RISE, EDGE_BOTH};
	// Multi-byte fields: rate offset, phase shift, rate readback, phase readback
	localparam int          MF_N     = 4;
	localparam logic [10:0] MF_BASE [MF_N] = '{11'h060, 11'h069, 11'h065, 11'h07D};
	localparam logic [2:0]  MF_LEN  [MF_N] = '{3'h5, 3'h4, 3'h4, 3'h4};
	localparam logic [39:0] RATE_RST  = 40'h00_0000_0000;
	localparam logic [31:0] PHASE_RST = 32'h0000_0000;
	// Host command registers on AXI4-Lite
	localparam logic [7:0]  H_ADDR   = 8'h00;
	localparam logic [7:0]  H_WDATA  = 8'h04;
	localparam logic [7:0]  H_CTRL   = 8'h08;
	localparam logic [7:0]  H_STAT   = 8'h0C;
	localparam int          CTRL_GO  = 0;
	localparam int          CTRL_WR  = 1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// Host link sequencer
	typedef enum logic [1:0] {
		HS_IDLE = 2'b01,
		HS_WAIT = 2'b10
	} ccr_hst_type;
endpackage

// File: common/ccr_link_if.sv
// Register link between host end and device end
`timescale 1ns/100ps
interface ccr_link_if;
	logic        req;
	logic        we;
	logic [10:0] addr;
	logic [7:0]  wdata;
	logic        ack;
	logic [7:0]  rdata;
	modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
	modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// File: verilog/ccr_event_bit.sv
// One latched status bit with synchroniser and edge select
`timescale 1ns/100ps
module ccr_event_bit
	import ccr_pkg::*;
#(
	parameter logic [1:0] EDGE = EDGE_RISE
)(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic sig_i,
	input  wire logic clr_i,
	output logic      level_o,
	output logic      flag_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic flag_q;
	wire  rise_w = s2_q & ~s3_q;
	wire  fall_w = ~s2_q & s3_q;
	// Set beats clear so an edge in the clearing cycle stays seen
	wire  set_w  = (EDGE[0] & rise_w) | (EDGE[1] & fall_w);
	wire  flag_d = set_w | (flag_q & ~clr_i);

	// Two-stage synchroniser, third stage only for edge history
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			s1_q   <= 1'b0;
			s2_q   <= 1'b0;
			s3_q   <= 1'b0;
			flag_q <= 1'b0;
		end
		else
		begin
			s1_q   <= sig_i;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			flag_q <= flag_d;
		end
	end

	assign level_o = s2_q;
	assign flag_o  = flag_q;
endmodule

// File: verilog/ccr_dev.sv
// Device end: register bank with staging, status bits and memory bank
//
// Operation
// - Decode 000h to 6FFh, byte-wide registers
// - Bit 7 is MSb, bit 0 LSb
// - Host writes zero to reserved locations
// - Host writes fixed bits with fixed value
// - Read-only fields ignore writes
// - Real-time bits show live signal level
// - Latched bits set on chosen edge
// - Writing one clears latched bit
// - Enabled latched bits raise interrupt request
// - Host ignores reserved status bits
// - Reset restores configuration defaults
// - Ascending writes, lower bytes staged
// - Last byte commits whole field
// - Mid-write reads return committed value
// - Lowest byte read snapshots whole field
// - Writes mid-read overwrite read staging
// - One shared write and read stage
// - Rate, phase offsets and two readbacks
// - Bank bit maps memory above 0x0
// - Bank register always at 0x0
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module ccr_dev
	import ccr_pkg::*;
#(
	parameter int NVM_DEPTH = 256
)(
	ccr_link_if.dev                 link,
	input  wire logic               SYS_CLK_I,
	input  wire logic               RSTN_I,
	input  wire logic [EV_N-1:0]    STAT_I,
	input  wire logic [31:0]        RATE_RB_I,
	input  wire logic [31:0]        PHASE_RB_I,
	output logic                    BANK_SEL_O,
	output logic [8*CFG_N-1:0]      CFG_O,
	output logic [39:0]             RATE_OFFSET_O,
	output logic [31:0]             PHASE_SHIFT_O,
	output logic                    IRQ_O
);
	localparam int NVM_AW = $clog2(NVM_DEPTH);

	logic [7:0]      cfg_q [CFG_N];
	logic            bank_q;
	logic [EV_N-1:0] ie_q;
	logic            irq_q;
	logic            ack_q;
	logic [7:0]      rdata_q;
	logic [39:0]     rate_q;
	logic [31:0]     phase_q;
	logic [39:0]     wstage_q;
	logic [39:0]     rstage_q;
	logic [7:0]      nvm_q [NVM_DEPTH];
	logic [EV_N-1:0] ev_level;
	logic [EV_N-1:0] ev_flag;
	logic [7:0]      cfg_rd;
	logic            cfg_any;
	logic [7:0]      rd_d;

	// Multi-byte decode: {hit, field id, byte index}
	function automatic logic [5:0] mf_decode(input logic [10:0] a);
		logic [5:0]  r;
		logic [10:0] off;
		r = 6'h00;
		for (int i = 0; i < MF_N; i++)
		begin
			off = a - MF_BASE[i];
			if (a >= MF_BASE[i] && off < {8'h00, MF_LEN[i]})
				r = {1'b1, 2'(i), off[2:0]};
		end
		return r;
	endfunction

	// Access qualifiers
	wire        in_space = link.addr <= ADDR_TOP;
	wire        is_bank  = link.addr == A_BANK;
	wire        nvm_sel  = bank_q & ~is_bank & in_space;
	wire        reg_sel  = ~bank_q & in_space;
	wire        wr       = link.req & link.we;
	wire        rd       = link.req & ~link.we;
	wire        nvm_ok   = 32'(link.addr) < NVM_DEPTH;
	wire [5:0]  mf       = mf_decode(link.addr);
	wire        mf_hit   = mf[5] & reg_sel;
	wire [1:0]  mf_id    = mf[4:3];
	wire [2:0]  mf_byte  = mf[2:0];
	wire        mf_rw    = ~mf_id[1];
	wire        mf_last  = mf_byte == MF_LEN[mf_id] - 3'h1;
	wire        hit_rt   = reg_sel & link.addr == A_RT;
	wire        hit_lat  = reg_sel & link.addr == A_LATCH;
	wire        hit_ie   = reg_sel & link.addr == A_IE;
	// Committed value of the addressed field, readbacks zero-extended
	wire [39:0] mf_cur   = (mf_id == 2'h0) ? rate_q :
		(mf_id == 2'h1) ? {8'h00, phase_q} :
		(mf_id == 2'h2) ? {8'h00, RATE_RB_I} : {8'h00, PHASE_RB_I};

	// Plain configuration registers, reserved bits forced to zero
	genvar g;
	for (g = 0; g < CFG_N; g++)
	begin : g_cfg
		always_ff @(posedge SYS_CLK_I)
		begin
			if (!RSTN_I)
				cfg_q[g] <= CFG_RST[g];
			else if (wr && reg_sel && link.addr == CFG_ADDR[g])
				cfg_q[g] <= link.wdata & CFG_MASK[g];
		end
		assign CFG_O[8*g +: 8] = cfg_q[g];
	end

	// Latched status cells; clear by writing one at the bit position
	for (g = 0; g < EV_N; g++)
	begin : g_ev
		ccr_event_bit #(
			.EDGE    (EV_EDGE[g])
		) u_ev (
			.clk_i   (SYS_CLK_I),
			.rstn_i  (RSTN_I),
			.sig_i   (STAT_I[g]),
			.clr_i   (wr & hit_lat & link.wdata[EV_LSB+g]),
			.level_o (ev_level[g]),
			.flag_o  (ev_flag[g])
		);
	end

	// Configuration read select
	always_comb
	begin
		cfg_rd  = 8'h00;
		cfg_any = 1'b0;
		for (int i = 0; i < CFG_N; i++)
		begin
			if (link.addr == CFG_ADDR[i])
			begin
				cfg_rd  = cfg_q[i];
				cfg_any = 1'b1;
			end
		end
	end

	// Read data select; anything unmatched reads zero
	always_comb
	begin
		rd_d = 8'h00;
		if (!in_space)
			rd_d = 8'h00;
		else if (is_bank)
			rd_d = 8'({7'h00, bank_q} << BANK_BIT);
		else if (nvm_sel)
			rd_d = nvm_ok ? nvm_q[link.addr[NVM_AW-1:0]] : 8'h00;
		else if (cfg_any)
			rd_d = cfg_rd;
		else if (hit_rt)
			rd_d = 8'({5'h00, ev_level} << EV_LSB);
		else if (hit_lat)
			rd_d = 8'({5'h00, ev_flag} << EV_LSB);
		else if (hit_ie)
			rd_d = 8'({5'h00, ie_q} << EV_LSB);
		else if (mf_hit)
			rd_d = (mf_byte == 3'h0) ? mf_cur[7:0] : rstage_q[8*mf_byte +: 8];
	end

	// Link answer, bank bit, enables and interrupt request
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
			bank_q  <= BANK_RST;
			ie_q    <= IE_RST;
			irq_q   <= 1'b0;
		end
		else
		begin
			ack_q <= link.req;
			if (rd)
				rdata_q <= rd_d;
			if (wr && is_bank)
				bank_q <= link.wdata[BANK_BIT];
			if (wr && hit_ie)
				ie_q <= link.wdata[EV_LSB +: EV_N];
			irq_q <= |(ev_flag & ie_q);
		end
	end

	// Memory bank; contents are not reset
	always_ff @(posedge SYS_CLK_I)
	begin
		if (wr && nvm_sel && nvm_ok)
			nvm_q[link.addr[NVM_AW-1:0]] <= link.wdata;
	end

	// One shared write stage for rate and phase, one shared read stage for all four fields
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			rate_q   <= RATE_RST;
			phase_q  <= PHASE_RST;
			wstage_q <= 40'h00_0000_0000;
			rstage_q <= 40'h00_0000_0000;
		end
		else
		begin
			if (rd && mf_hit && mf_byte == 3'h0)
				rstage_q <= mf_cur;
			if (wr && mf_hit && mf_rw)
			begin
				rstage_q[8*mf_byte +: 8] <= link.wdata;
				if (!mf_last)
					wstage_q[8*mf_byte +: 8] <= link.wdata;
				else if (mf_id == 2'h0)
					rate_q <= {link.wdata, wstage_q[31:0]};
				else
					phase_q <= {link.wdata, wstage_q[23:0]};
			end
		end
	end

	// Field outputs change only on commit, so mid-write reads see old value
	assign RATE_OFFSET_O = rate_q;
	assign PHASE_SHIFT_O = phase_q;
	assign BANK_SEL_O    = bank_q;
	assign IRQ_O         = irq_q;
	assign link.ack      = ack_q;
	assign link.rdata    = rdata_q;
endmodule

// File: verilog/ccr_host.sv
// Host end: AXI4-Lite command registers driving the register link
`timescale 1ns/100ps
module ccr_host
	import ccr_pkg::*;
#(
	parameter int AXI_AW = 8
)(
	ccr_link_if.host                link,
	input  wire logic               SYS_CLK_I,
	input  wire logic               RSTN_I,
	input  wire logic [AXI_AW-1:0]  AXI_AWADDR_I,
	input  wire logic               AXI_AWVALID_I,
	output logic                    AXI_AWREADY_O,
	input  wire logic [31:0]        AXI_WDATA_I,
	input  wire logic [3:0]         AXI_WSTRB_I,
	input  wire logic               AXI_WVALID_I,
	output logic                    AXI_WREADY_O,
	output logic [1:0]              AXI_BRESP_O,
	output logic                    AXI_BVALID_O,
	input  wire logic               AXI_BREADY_I,
	input  wire logic [AXI_AW-1:0]  AXI_ARADDR_I,
	input  wire logic               AXI_ARVALID_I,
	output logic                    AXI_ARREADY_O,
	output logic [31:0]             AXI_RDATA_O,
	output logic [1:0]              AXI_RRESP_O,
	output logic                    AXI_RVALID_O,
	input  wire logic               AXI_RREADY_I
);
	logic              awrdy_q;
	logic              wrdy_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              arrdy_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic [10:0]       cmd_addr_q;
	logic [7:0]        cmd_wdata_q;
	logic              done_q;
	logic [7:0]        ans_q;
	logic              req_q;
	logic              we_q;
	ccr_hst_type       st_q;

	// Address match shared by read and write decode
	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		return a == H_ADDR || a == H_WDATA || a == H_CTRL || a == H_STAT;
	endfunction

	wire        busy    = st_q != HS_IDLE;
	wire        do_wr   = ~awrdy_q & ~wrdy_q & ~bvalid_q;
	wire        w_ctrl  = do_wr & awaddr_q == H_CTRL & wstrb_q[0];
	// A start while busy is dropped: one access in flight at a time
	wire        go      = w_ctrl & wdata_q[CTRL_GO] & ~busy;
	wire [31:0] stat_w  = {16'h0000, ans_q, 6'h00, done_q, busy};
	wire [31:0] rd_mux  = (AXI_ARADDR_I == H_ADDR)  ? {21'h000000, cmd_addr_q} :
		(AXI_ARADDR_I == H_WDATA) ? {24'h000000, cmd_wdata_q} :
		(AXI_ARADDR_I == H_STAT)  ? stat_w : 32'h0000_0000;

	// Write channel: address and data taken in either order
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			awrdy_q  <= 1'b1;
			wrdy_q   <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end
		else
		begin
			if (awrdy_q && AXI_AWVALID_I)
			begin
				awrdy_q  <= 1'b0;
				awaddr_q <= AXI_AWADDR_I;
			end
			if (wrdy_q && AXI_WVALID_I)
			begin
				wrdy_q  <= 1'b0;
				wdata_q <= AXI_WDATA_I;
				wstrb_q <= AXI_WSTRB_I;
			end
			if (do_wr)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && AXI_BREADY_I)
			begin
				bvalid_q <= 1'b0;
				awrdy_q  <= 1'b1;
				wrdy_q   <= 1'b1;
			end
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			arrdy_q  <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end
		else if (arrdy_q && AXI_ARVALID_I)
		begin
			arrdy_q  <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= mapped(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_q && AXI_RREADY_I)
		begin
			rvalid_q <= 1'b0;
			arrdy_q  <= 1'b1;
		end
	end

	// Command registers and link sequencer; byte order is software's duty
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			cmd_addr_q  <= 11'h000;
			cmd_wdata_q <= 8'h00;
			done_q      <= 1'b0;
			ans_q       <= 8'h00;
			req_q       <= 1'b0;
			we_q        <= 1'b0;
			st_q        <= HS_IDLE;
		end
		else
		begin
			req_q <= 1'b0;
			if (do_wr && awaddr_q == H_ADDR && wstrb_q[0])
				cmd_addr_q[7:0] <= wdata_q[7:0];
			if (do_wr && awaddr_q == H_ADDR && wstrb_q[1])
				cmd_addr_q[10:8] <= wdata_q[10:8];
			if (do_wr && awaddr_q == H_WDATA && wstrb_q[0])
				cmd_wdata_q <= wdata_q[7:0];
			case (st_q)
				HS_IDLE:
				begin
					if (go)
					begin
						req_q  <= 1'b1;
						we_q   <= wdata_q[CTRL_WR];
						done_q <= 1'b0;
						st_q   <= HS_WAIT;
					end
				end
				HS_WAIT:
				begin
					if (link.ack)
					begin
						if (!we_q)
							ans_q <= link.rdata;
						done_q <= 1'b1;
						st_q   <= HS_IDLE;
					end
				end
				default:
					st_q <= HS_IDLE;
			endcase
		end
	end

	assign link.req      = req_q;
	assign link.we       = we_q;
	assign link.addr     = cmd_addr_q;
	assign link.wdata    = cmd_wdata_q;
	assign AXI_AWREADY_O = awrdy_q;
	assign AXI_WREADY_O  = wrdy_q;
	assign AXI_BVALID_O  = bvalid_q;
	assign AXI_BRESP_O   = bresp_q;
	assign AXI_ARREADY_O = arrdy_q;
	assign AXI_RVALID_O  = rvalid_q;
	assign AXI_RDATA_O   = rdata_q;
	assign AXI_RRESP_O   = rresp_q;
endmodule

// File: bench/ccr_link_props.sv
// Link assertions between host end and device end
`timescale 1ns/100ps
module ccr_link_props
	import ccr_pkg::*;
(
	input wire logic        SYS_CLK_I,
	input wire logic        RSTN_I,
	input wire logic        req,
	input wire logic        we,
	input wire logic [10:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        ack,
	input wire logic [7:0]  rdata
);
	logic       bank_q;
	logic [2:0] ie_q;
	logic       rd;
	logic       wr;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// Decoded link strobes
	assign rd = req && !we;
	assign wr = req && we;
	// Shadow of bank bit and enables, as written over the link
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			bank_q <= BANK_RST;
			ie_q   <= IE_RST;
		end
		else if (wr && addr == A_BANK)
			bank_q <= wdata[BANK_BIT];
		else if (wr && !bank_q && addr == A_IE)
			ie_q <= wdata[EV_LSB+:EV_N];
	end
	a_ack_after_req: assert property (req |=> ack)
		else $error("no answer after request");
	a_ack_has_cause: assert property (ack |-> $past(req))
		else $error("answer without request");
	a_req_one_pulse: assert property (req |=> !req)
		else $error("request longer than one cycle");
	a_rdata_steady: assert property ($changed(rdata) |-> ack && $past(rd))
		else $error("read byte moved outside a read answer");
	a_beyond_zero: assert property (rd && addr > ADDR_TOP |=> rdata == 8'h00)
		else $error("read beyond top not zero");
	a_bank_readback: assert property (rd && addr == A_BANK |=> rdata == {7'h00, bank_q})
		else $error("bank register readback wrong");
	a_status_reserved: assert property (rd && !bank_q && (addr == A_RT || addr == A_LATCH)
		|=> rdata[7:6] == 2'h0 && rdata[2:0] == 3'h0)
		else $error("reserved status bits not zero");
	a_enable_readback: assert property (rd && !bank_q && addr == A_IE |=> rdata == {2'h0, ie_q, 3'h0})
		else $error("enable register readback wrong");
endmodule

// File: bench/clock_chip_register_access_test.sv
// Bench driving the host end over AXI4-Lite, device end facing it
`timescale 1ns/100ps
module clock_chip_register_access_test
	import ccr_pkg::*;
;
	logic               clk = 1'b0;
	logic               rst_n;
	logic [7:0]         awaddr, araddr;
	logic [31:0]        wdat, rdat, rate_rb, ph_rb, ph;
	logic               awvalid, wvalid, bready, arvalid, rready;
	logic               awready, wready, bvalid, arready, rvalid, bank, irq;
	logic [1:0]         bresp, rresp;
	logic [2:0]         stat;
	logic [8*CFG_N-1:0] cfg;
	logic [39:0]        rate;
	int                 miscompares, cmp_count, cycles = 0;
	ccr_link_if link ();
	ccr_dev u_ccr_dev (.link(link), .SYS_CLK_I(clk), .RSTN_I(rst_n), .STAT_I(stat), .RATE_RB_I(rate_rb),
		.PHASE_RB_I(ph_rb), .BANK_SEL_O(bank), .CFG_O(cfg), .RATE_OFFSET_O(rate), .PHASE_SHIFT_O(ph), .IRQ_O(irq));
	ccr_host u_ccr_host (.link(link), .SYS_CLK_I(clk), .RSTN_I(rst_n), .AXI_AWADDR_I(awaddr),
		.AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdat), .AXI_WSTRB_I(4'hF),
		.AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
		.AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
		.AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready));
	ccr_link_props u_chk (.SYS_CLK_I(clk), .RSTN_I(rst_n), .req(link.req), .we(link.we), .addr(link.addr),
		.wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
	// Free-running clock
	initial
	begin
		forever #4 clk = ~clk;
	end
	// Hang guard: a run should need under two thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			report_and_stop;
		end
	end
	task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask
	// AXI write: both channels offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clk);
		awaddr <= a;
		wdat <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdat;
				r = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask
	// One link access through the command registers; reads compare with d
	task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d, input string m);
		logic [1:0]  r;
		logic [31:0] s;
		axi_wr(H_ADDR, {21'h0, a}, r);
		axi_wr(H_WDATA, {24'h0, d}, r);
		axi_wr(H_CTRL, {30'h0, w, 1'b1}, r);
		s = 32'h0;
		while (s[1:0] !== 2'b10)
			axi_rd(H_STAT, s, r);
		if (!w)
			chk(s[15:8], d, m);
	endtask
	task t_reset;
		logic [1:0]  r;
		logic [31:0] d;
		chk({rate, ph[7:0], bank, irq}, 50'h0, "outputs at reset");
		for (int g = 0; g < CFG_N; g++)
		begin
			acc(1'b0, CFG_ADDR[g], CFG_RST[g], "cfg default");
			chk(cfg[8*g+:8], CFG_RST[g], "cfg out default");
		end
		acc(1'b0, 11'h010, 8'h00, "unlisted");
		acc(1'b0, 11'h700, 8'h00, "beyond top");
		axi_rd(8'h14, d, r);
		chk({r, d}, {RESP_SLVERR, 32'h0}, "axi bad read");
		axi_wr(8'h10, 32'h0, r);
		chk(r, RESP_SLVERR, "axi bad write");
		$display("reset test done");
	endtask
	task t_cfg;
		for (int g = 0; g < CFG_N; g++)
			acc(1'b1, CFG_ADDR[g], (8'hA5 ^ 8'(g)) & CFG_MASK[g], "");
		for (int g = 0; g < CFG_N; g++)
		begin
			acc(1'b0, CFG_ADDR[g], (8'hA5 ^ 8'(g)) & CFG_MASK[g], "cfg rw");
			chk(cfg[8*g+:8], (8'hA5 ^ 8'(g)) & CFG_MASK[g], "cfg out");
		end
		$display("config test done");
	endtask
	task t_multi;
		for (int i = 0; i < 4; i++)
			acc(1'b1, MF_BASE[0] + 11'(i), 8'h10 + 8'(i), "");
		chk(rate, RATE_RST, "no early commit");
		acc(1'b0, MF_BASE[0], 8'h00, "mid write read");
		acc(1'b1, MF_BASE[0] + 11'h4, 8'h55, "");
		chk(rate, 40'h55_1312_1110, "rate commit");
		for (int i = 0; i < 5; i++)
			acc(1'b0, MF_BASE[0] + 11'(i), 8'h10 + 8'(i) + (i == 4 ? 8'h41 : 8'h00), "rate read");
		for (int i = 0; i < 4; i++)
			acc(1'b1, MF_BASE[1] + 11'(i), 8'hC0 + 8'(i), "");
		chk(ph, 32'hC3C2_C1C0, "phase commit");
		$display("multi byte test done");
	endtask
	task t_snap;
		@(posedge clk);
		rate_rb <= 32'hA1B2_C3D4;
		ph_rb <= 32'h0F1E_2D3C;
		acc(1'b0, MF_BASE[2], 8'hD4, "rb byte0");
		@(posedge clk);
		rate_rb <= 32'h0;
		acc(1'b1, MF_BASE[2] + 11'h1, 8'h77, "");
		acc(1'b0, MF_BASE[2] + 11'h1, 8'hC3, "rb frozen");
		// Shared stage: this snapshot replaces the rate one
		acc(1'b0, MF_BASE[3], 8'h3C, "ph rb byte0");
		@(posedge clk);
		ph_rb <= 32'h0;
		acc(1'b0, MF_BASE[3] + 11'h3, 8'h0F, "ph rb byte3");
		acc(1'b0, MF_BASE[0], 8'h10, "offset byte0");
		acc(1'b1, MF_BASE[0] + 11'h1, 8'h3C, "");
		acc(1'b0, MF_BASE[0] + 11'h1, 8'h3C, "stage overwritten");
		acc(1'b0, MF_BASE[0] + 11'h2, 8'h12, "stage kept");
		chk(rate, 40'h55_1312_1110, "uncommitted");
		$display("snapshot test done");
	endtask
	task t_status;
		@(posedge clk);
		stat <= 3'h7;
		acc(1'b0, A_LATCH, 8'h38, "rising set");
		acc(1'b0, A_RT, 8'h38, "live high");
		acc(1'b1, A_LATCH, 8'h38, "");
		acc(1'b0, A_LATCH, 8'h00, "cleared");
		@(posedge clk);
		stat <= 3'h0;
		acc(1'b0, A_RT, 8'h00, "live low");
		acc(1'b0, A_LATCH, 8'h28, "falling set");
		acc(1'b1, A_LATCH, 8'h08, "");
		acc(1'b0, A_LATCH, 8'h20, "zero keeps");
		chk(irq, 1'b0, "irq masked");
		acc(1'b1, A_IE, 8'h20, "");
		chk(irq, 1'b1, "irq raised");
		acc(1'b0, A_IE, 8'h20, "enable rw");
		acc(1'b1, A_LATCH, 8'h20, "");
		chk(irq, 1'b0, "irq cleared");
		$display("status test done");
	endtask
	task t_bank;
		acc(1'b1, A_BANK, 8'h01, "");
		chk(bank, 1'b1, "bank out");
		acc(1'b1, 11'h010, 8'h5A, "");
		acc(1'b0, 11'h010, 8'h5A, "memory word");
		acc(1'b0, A_BANK, 8'h01, "bank reg");
		acc(1'b1, A_BANK, 8'h00, "");
		acc(1'b0, 11'h010, 8'h00, "regs back");
		acc(1'b0, CFG_ADDR[0], 8'hA5 & CFG_MASK[0], "cfg kept");
		$display("bank test done");
	endtask
	task t_rerst;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({rate, ph[7:0], bank, irq}, 50'h0, "outputs after reset");
		chk({cfg[119:64], cfg[7:0]}, 64'h0, "cfg after reset");
		chk(cfg[63:8], 56'h0, "cfg mid after reset");
		acc(1'b0, A_IE, 8'h00, "enables after reset");
		$display("second reset test done");
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		{awaddr, araddr, wdat, awvalid, wvalid, bready, arvalid, rready} = '0;
		{stat, rate_rb, ph_rb} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_cfg;
		t_multi;
		t_snap;
		t_status;
		t_bank;
		t_rerst;
		report_and_stop;
	end
endmodule
